// >>> src/plr_map.svh
// constants for the position loop and range limit block
// assumes inclusion by bare name from design files
`ifndef PLR_MAP_SVH
`define PLR_MAP_SVH

// register byte offsets (avalon word aligned)
`define PLR_REG_CTRL      8'h00
`define PLR_REG_GAIN      8'h04
`define PLR_REG_CORR      8'h08
`define PLR_REG_MIN_LIM   8'h0C
`define PLR_REG_MAX_LIM   8'h10
`define PLR_REG_TT_RANGE  8'h14
`define PLR_REG_STATUS    8'h18
`define PLR_REG_MASK      8'h1C
`define PLR_REG_ACT_POS   8'h20
`define PLR_REG_SPD_OUT   8'h24

// control register fields
`define PLR_CTRL_POL_BIT    0
`define PLR_CTRL_TT_BIT     1
`define PLR_CTRL_HOMED_BIT  2
`define PLR_CTRL_MODE_LSB   3
`define PLR_CTRL_MODE_MSB   4

// status register fields
`define PLR_ST_MIN_BIT   0
`define PLR_ST_MAX_BIT   1
`define PLR_ST_WRAP_BIT  2

// fixed point: position in 1/10000 revolution
`define PLR_POS_SCALE    32'sd10000
`define PLR_GAIN_SCALE   32'sd10000
`define PLR_GAIN_MAX     16'd9999
`define PLR_LIN_MIN      40'shFE_C780_0000
`define PLR_LIN_MAX      40'sh01_387F_FFFE
`define PLR_TT_MIN       32'd10000
`define PLR_TT_MAX       32'd1000000000

// reset values
`define PLR_RST_GAIN     16'h07D0
`define PLR_RST_CORR     16'h0BB8
`define PLR_RST_MIN      40'shFE_C780_0000
`define PLR_RST_MAX      40'sh01_387F_FFFE
`define PLR_RST_TT       32'h3B9A_CA00

`endif

// >>> src/plr_pkg.sv
// types for the position loop and range limit block
// assumes plr_map.svh is compiled alongside
package plr_pkg;

  typedef enum logic [1:0] {
    PLR_MODE_POS,
    PLR_MODE_SPEED,
    PLR_MODE_CURRENT
  } plr_mode_t;

  typedef struct packed {
    logic polarity_neg;
    logic turntable;
    logic homed;
    logic [1:0] mode;
  } plr_ctrl_t;

  typedef struct packed {
    logic wrap;
    logic max_err;
    logic min_err;
  } plr_status_t;

  typedef struct packed {
    logic signed [39:0] min_lim;
    logic signed [39:0] max_lim;
  } plr_limits_t;

endpackage

// >>> src/plr_limit_check.sv
// software position limit comparison for one position value
// assumes both positions and limits share the 1/10000 rev scale
`include "plr_map.svh"

module plr_limit_check (
  // position and limits
  input wire logic signed [39:0] pos_i,
  input wire plr_pkg::plr_limits_t lim_i,
  // comparison results
  output logic below_o,
  output logic above_o
);

  assign below_o = pos_i < lim_i.min_lim;
  assign above_o = pos_i > lim_i.max_lim;

endmodule

// >>> src/plr_top.sv
// position loop, polarity and range limit block with avalon slave
// assumes a synchronous trajectory source on clk_i; encoder input is synchronised from its pin domain
//
// Operation
// RULE_01: speed correction is gain times position error, gain 0 to 0.9999
// RULE_02: position loop correction is clamped to the programmed magnitude
// RULE_03: demand speed stays within trajectory speed plus or minus correction
// RULE_04: positive polarity counts up clockwise, negative counts up ccw
// RULE_05: negative polarity also inverts current and speed setpoints
// RULE_06: limits span -524288 to under 524288 rev; turntable 0 to 100000 (written limits reach only about +/-214748 rev)
// RULE_07: after homing, setpoint or actual below minimum flags an error
// RULE_08: after homing, setpoint or actual above maximum flags an error
// RULE_09: in turntable mode the position counter wraps to zero at the range
// RULE_10: controller programs turntable range within 1 to 100000 revolutions
// RULE_11: controller gives turntable range exactly, at most four decimals
// RULE_12: turntable range is an integer count of 1/10000 revolution
// RULE_13: positions are signed fixed point in 1/10000 revolution
`include "plr_map.svh"

module plr_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // trajectory and setpoints
  input wire logic signed [39:0] pos_demand_i,
  input wire logic signed [31:0] traj_speed_i,
  input wire logic signed [31:0] speed_setpoint_i,
  input wire logic signed [31:0] current_setpoint_i,
  // encoder increments, 1/10000 rev in shaft cw sense, pin domain
  input wire logic enc_valid_i,
  input wire logic signed [15:0] enc_delta_i,
  // outputs
  output logic signed [31:0] speed_cmd_o,
  output logic signed [31:0] current_cmd_o,
  output logic signed [39:0] act_pos_o,
  output logic pos_error_o,
  output logic irq_o
);

  // ==========================================================
  // register storage
  // ==========================================================
  plr_pkg::plr_ctrl_t ctrl;
  logic [15:0] position_loop_gain;
  logic [15:0] corr_speed;
  plr_pkg::plr_limits_t lims;
  logic [31:0] tt_range;
  plr_pkg::plr_status_t status;
  plr_pkg::plr_status_t mask;
  logic ack;

  // ==========================================================
  // encoder input synchroniser
  // ==========================================================
  logic [16:0] enc_s1;
  logic [16:0] enc_s2;
  logic enc_seen;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      enc_s1 <= 17'h0_0000;
      enc_s2 <= 17'h0_0000;
      enc_seen <= 1'b0;
    end
    else
    begin
      enc_s1 <= {enc_valid_i, enc_delta_i};
      enc_s2 <= enc_s1;
      enc_seen <= enc_s2[16];
    end
  end

  // one update per rising valid edge
  // delta rides with valid, so the source holds it while valid is high
  wire enc_strobe = enc_s2[16] & ~enc_seen;
  wire signed [15:0] enc_raw = enc_s2[15:0];
  // negative polarity counts ccw as increasing
  wire signed [15:0] enc_step =
    ctrl.polarity_neg ? -enc_raw : enc_raw; // RULE_04

  // ==========================================================
  // actual position counter
  // ==========================================================
  logic signed [39:0] act_pos;
  wire signed [39:0] tt_top = {8'h00, tt_range}; // RULE_12
  wire signed [39:0] pos_sum = act_pos + 40'(enc_step); // RULE_13
  // a step longer than the range wraps only once, so steps stay small
  wire wrap_hi = ctrl.turntable && pos_sum >= tt_top;
  wire wrap_lo = ctrl.turntable && pos_sum < 40'sh00_0000_0000;
  wire signed [39:0] lin_sat =
    pos_sum > `PLR_LIN_MAX ? `PLR_LIN_MAX :
    pos_sum < `PLR_LIN_MIN ? `PLR_LIN_MIN : pos_sum; // RULE_06
  wire signed [39:0] next_act_pos =
    wrap_hi ? pos_sum - tt_top :
    wrap_lo ? pos_sum + tt_top : lin_sat; // RULE_09

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      act_pos <= 40'sh00_0000_0000;
    else if (enc_strobe)
      act_pos <= next_act_pos;
  end

  assign act_pos_o = act_pos;

  // ==========================================================
  // proportional position loop
  // ==========================================================
  wire signed [39:0] pos_diff = pos_demand_i - act_pos;
  wire signed [56:0] prod =
    57'(pos_diff) * 57'(signed'({1'b0, position_loop_gain})); // RULE_01
  // signed division truncates toward zero, so tiny errors give no push
  wire signed [56:0] corr_raw = prod / 57'(`PLR_GAIN_SCALE);
  wire signed [56:0] corr_lim = 57'(signed'({1'b0, corr_speed}));
  wire signed [31:0] corr_clamp =
    corr_raw > corr_lim ? 32'(corr_lim) :
    corr_raw < -corr_lim ? 32'(-corr_lim) : 32'(corr_raw); // RULE_02
  // demand speed never leaves traj +/- correction
  wire signed [31:0] pos_speed = traj_speed_i + corr_clamp; // RULE_03

  wire plr_pkg::plr_mode_t mode = plr_pkg::plr_mode_t'(ctrl.mode);
  wire signed [31:0] spd_inv =
    ctrl.polarity_neg ? -speed_setpoint_i : speed_setpoint_i; // RULE_05
  wire signed [31:0] cur_inv =
    ctrl.polarity_neg ? -current_setpoint_i : current_setpoint_i; // RULE_05
  // mode code 3 commands neither speed nor current
  wire signed [31:0] next_speed =
    mode == plr_pkg::PLR_MODE_POS ? pos_speed :
    mode == plr_pkg::PLR_MODE_SPEED ? spd_inv : 32'sh0000_0000;
  wire signed [31:0] next_current =
    mode == plr_pkg::PLR_MODE_CURRENT ? cur_inv : 32'sh0000_0000;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      speed_cmd_o <= 32'sh0000_0000;
      current_cmd_o <= 32'sh0000_0000;
    end
    else
    begin
      speed_cmd_o <= next_speed;
      current_cmd_o <= next_current;
    end
  end

  // ==========================================================
  // software limits
  // ==========================================================
  logic dem_below;
  logic dem_above;
  logic act_below;
  logic act_above;

  plr_limit_check u_dem_chk (
    .pos_i(pos_demand_i),
    .lim_i(lims),
    .below_o(dem_below),
    .above_o(dem_above)
  );

  plr_limit_check u_act_chk (
    .pos_i(act_pos),
    .lim_i(lims),
    .below_o(act_below),
    .above_o(act_above)
  );

  // limits only act once homing is done
  wire ev_min = ctrl.homed & (dem_below | act_below); // RULE_07
  wire ev_max = ctrl.homed & (dem_above | act_above); // RULE_08
  wire ev_wrap = enc_strobe & (wrap_hi | wrap_lo);

  // error level is recomputed each cycle while a breach lasts
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pos_error_o <= 1'b0;
    else
      pos_error_o <= ev_min | ev_max; // RULE_07 RULE_08
  end

  // ==========================================================
  // avalon decode
  // ==========================================================
  // writes land at the edge that raises ack; the master still holds then
  wire req = (avs_read_i | avs_write_i) & ~ack;
  wire wr = avs_write_i & req;
  wire rd = avs_read_i & req;
  wire sel_ctrl = avs_address_i == `PLR_REG_CTRL;
  wire sel_gain = avs_address_i == `PLR_REG_GAIN;
  wire sel_corr = avs_address_i == `PLR_REG_CORR;
  wire sel_min = avs_address_i == `PLR_REG_MIN_LIM;
  wire sel_max = avs_address_i == `PLR_REG_MAX_LIM;
  wire sel_tt = avs_address_i == `PLR_REG_TT_RANGE;
  wire sel_st = avs_address_i == `PLR_REG_STATUS;
  wire sel_mask = avs_address_i == `PLR_REG_MASK;
  wire sel_pos = avs_address_i == `PLR_REG_ACT_POS;
  wire sel_spd = avs_address_i == `PLR_REG_SPD_OUT;
  wire [31:0] wdat = avs_writedata_i;
  wire full_word = &avs_byteenable_i;
  wire [15:0] gain_w =
    wdat[15:0] > `PLR_GAIN_MAX ? `PLR_GAIN_MAX : wdat[15:0]; // RULE_01
  // sign extend 32 bit write of limits in 1/10000 rev
  // so written limits reach only about +/-214748 rev
  wire signed [39:0] lim_w = 40'(signed'(wdat)); // RULE_06
  wire [31:0] tt_w =
    wdat < `PLR_TT_MIN ? `PLR_TT_MIN :
    wdat > `PLR_TT_MAX ? `PLR_TT_MAX : wdat; // RULE_10

  // control word fields sit at their own bit positions
  wire plr_pkg::plr_ctrl_t ctrl_w = '{
    polarity_neg: wdat[`PLR_CTRL_POL_BIT],
    turntable: wdat[`PLR_CTRL_TT_BIT],
    homed: wdat[`PLR_CTRL_HOMED_BIT],
    mode: wdat[`PLR_CTRL_MODE_MSB:`PLR_CTRL_MODE_LSB]
  };

  // unmapped offsets read as zero
  wire [31:0] rd_mux =
    sel_ctrl ? {27'h0, ctrl.mode, ctrl.homed, ctrl.turntable,
                ctrl.polarity_neg} :
    sel_gain ? {16'h0, position_loop_gain} :
    sel_corr ? {16'h0, corr_speed} :
    sel_min ? lims.min_lim[31:0] :
    sel_max ? lims.max_lim[31:0] :
    sel_tt ? tt_range :
    sel_st ? {29'h0, status} :
    sel_mask ? {29'h0, mask} :
    sel_pos ? act_pos[31:0] :
    sel_spd ? speed_cmd_o : 32'h0000_0000;

  // ==========================================================
  // register writes and reads
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl <= 5'h00;
      position_loop_gain <= `PLR_RST_GAIN;
      corr_speed <= `PLR_RST_CORR;
      lims.min_lim <= `PLR_RST_MIN;
      lims.max_lim <= `PLR_RST_MAX;
      tt_range <= `PLR_RST_TT;
      mask <= 3'h0;
      ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack <= req;
      if (rd)
        avs_readdata_o <= rd_mux;
      if (wr && full_word)
      begin
        if (sel_ctrl)
          ctrl <= ctrl_w;
        else if (sel_gain)
          position_loop_gain <= gain_w;
        else if (sel_corr)
          corr_speed <= wdat[15:0];
        else if (sel_min)
          lims.min_lim <= lim_w;
        else if (sel_max)
          lims.max_lim <= lim_w;
        else if (sel_tt)
          tt_range <= tt_w; // RULE_12
        else if (sel_mask)
          mask <= wdat[2:0];
      end
    end
  end

  // sticky status, a read clears it but a new event wins
  wire rd_clr = rd & sel_st;
  wire [2:0] ev_vec = {ev_wrap, ev_max, ev_min};
  wire [2:0] next_status = (rd_clr ? 3'h0 : status) | ev_vec;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      status <= 3'h0;
    else
      status <= next_status;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  // status and mask share one layout; one level interrupt
  assign irq_o = |(status & mask);

endmodule

// >>> verification/plr_checker.sv
// checker for the plr_top ports
// assumes a bind onto plr_top and a single clock domain
module plr_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // encoder, current path, interrupt
  input wire logic enc_valid_i,
  input wire logic signed [39:0] act_pos_o,
  input wire logic signed [31:0] current_setpoint_i,
  input wire logic signed [31:0] current_cmd_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // helpers
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] quiet;
  wire req = avs_read_i | avs_write_i;
  // edges since the last step strobe, saturating
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      quiet <= 4'h0;
    else if (enc_valid_i)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  sequence s_wait;
    req && avs_waitrequest_o;
  endsequence
  // ========
  // assertions
  chk_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
  chk_rd_first: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read answered at once");
  chk_wr_first: assert property ($rose(avs_write_i) |-> avs_waitrequest_o)
    else $error("write answered at once");
  chk_wait_one: assert property (s_wait ##1 req |-> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  chk_rd_stand: assert property (
    $changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved without read");
  chk_cur_sign: assert property (
    current_cmd_o == 32'sh0 || current_cmd_o == $past(current_setpoint_i)
      || current_cmd_o == -$past(current_setpoint_i))
    else $error("current command not from setpoint");
  chk_pos_quiet: assert property (
    quiet > 4'h7 |-> $stable(act_pos_o))
    else $error("position moved without step");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(req))
    else $error("interrupt fell without access");
endmodule

// >>> verification/plr_enc_model.sv
// encoder side model: one step strobe at a time
// assumes clk_i is the block clock
module plr_enc_model (
  // clock
  input wire logic clk_i,
  // step output
  output logic enc_valid_o,
  output logic signed [15:0] enc_delta_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    enc_valid_o = 1'b0;
    enc_delta_o = 16'h5A5A;
  end
  // strobe held past the sync stage; delta is scrambled once released
  task automatic step(input logic signed [15:0] d);
    @(posedge clk_i);
    enc_delta_o <= d;
    enc_valid_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    enc_valid_o <= 1'b0;
    enc_delta_o <= ~d;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// >>> verification/plr_top_tb.sv
// bench for plr_top with an encoder model and a reference model
// assumes the design, plr_checker and plr_enc_model are compiled first
module plr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // signals and model state
  logic clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, p, m;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic signed [39:0] pos_demand_i = 40'sh0, act_pos_o;
  logic signed [31:0] traj_speed_i = 32'sh0, speed_setpoint_i = 32'sh0;
  logic signed [31:0] current_setpoint_i = 32'sh0, speed_cmd_o, current_cmd_o;
  logic signed [15:0] enc_delta_i;
  logic avs_waitrequest_o, pos_error_o, irq_o, enc_valid_i;
  int bad_count = 0, check_count = 0, cyc = 0, i;
  longint mp = 0, g, c, dm, tr, d, s, u;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C,
    8'h30};
  logic [31:0] rv [8] = '{32'h0, 32'h7D0, 32'hBB8, 32'hC780_0000,
    32'h387F_FFFE, 32'h3B9A_CA00, 32'h0, 32'h0};
  int off [6] = '{0, 1001, 1000, -1001, -1000, 0};
  always #2 clk_i = ~clk_i;
  plr_top dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .pos_demand_i, .traj_speed_i, .speed_setpoint_i, .current_setpoint_i,
    .enc_valid_i, .enc_delta_i, .speed_cmd_o, .current_cmd_o, .act_pos_o,
    .pos_error_o, .irq_o);
  plr_enc_model enc (.clk_i, .enc_valid_o(enc_valid_i),
    .enc_delta_o(enc_delta_i));
  // ========
  // tasks and reference model
  task automatic chk(input logic [63:0] v, e);
    check_count++;
    if (v !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %0h want %0h", $time, v, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic longint spd(longint e, t, k, r);
    e = e * k / 10000;
    if (e > r)
      e = r;
    if (e < -r)
      e = -r;
    return t + e;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end
  // ========
  // tests
  initial
  begin
    i = $urandom(34);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      bus(0, ra[i], 0);
      chk(q, rv[i]);
    end
    avs_byteenable_i <= 4'h3;
    bus(1, 8'h04, 32'h0000_4E20);
    avs_byteenable_i <= 4'hF;
    bus(0, 8'h04, 0);
    chk(q, 32'h0000_07D0);
    bus(1, 8'h04, 32'h0000_4E20);
    bus(0, 8'h04, 0);
    chk(q, 32'h0000_270F);
    for (i = 0; i < 6; i++)
    begin
      g = i ? $urandom % 10000 : 9999;
      c = $urandom % 500 + 1;
      bus(1, 8'h04, g[31:0]);
      bus(1, 8'h08, c[31:0]);
      dm = longint'($urandom % 2000) - 1000;
      tr = longint'($urandom % 6000) - 3000;
      @(posedge clk_i);
      pos_demand_i <= dm[39:0];
      traj_speed_i <= tr[31:0];
      wt(2);
      chk(speed_cmd_o, spd(dm - mp, tr, g, c));
    end
    for (p = 0; p < 2; p++)
    begin
      bus(1, 8'h00, p);
      d = $urandom % 4000 + 1;
      enc.step(d[15:0]);
      mp += p ? -d : d;
      wt(0);
      chk(act_pos_o, mp);
    end
    for (m = 1; m < 3; m++)
      for (p = 0; p < 2; p++)
      begin
        bus(1, 8'h00, p | m << 3);
        s = longint'($urandom % 20000) - 10000;
        u = longint'($urandom % 20000) - 10000;
        @(posedge clk_i);
        speed_setpoint_i <= s[31:0];
        current_setpoint_i <= u[31:0];
        wt(1);
        if (m == 1)
          chk(speed_cmd_o, p ? -s : s);
        chk(current_cmd_o, m == 2 ? (p ? -u : u) : 0);
      end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    mp = 0;
    // 1.0625 rev, exact in four decimals
    bus(1, 8'h14, 32'h0000_2981);
    bus(1, 8'h00, 32'h0000_0002);
    for (i = 0; i < 4; i++)
    begin
      d = i < 3 ? 4000 : -2000;
      enc.step(d[15:0]);
      mp = (mp + d + 10625) % 10625;
      wt(0);
      chk(act_pos_o, mp);
    end
    chk(irq_o, 0);
    bus(1, 8'h1C, 32'h0000_0004);
    wt(0);
    chk(irq_o, 1);
    bus(0, 8'h18, 0);
    chk(q, 32'h0000_0004);
    wt(0);
    chk(irq_o, 0);
    s = mp - 1000;
    bus(1, 8'h0C, s[31:0]);
    s = mp + 1000;
    bus(1, 8'h10, s[31:0]);
    bus(1, 8'h00, 32'h0000_0004);
    for (i = 0; i < 6; i++)
    begin
      dm = mp + off[i];
      @(posedge clk_i);
      pos_demand_i <= dm[39:0];
      wt(2);
      chk(pos_error_o, off[i] > 1000 || off[i] < -1000);
    end
    enc.step(16'sh05DC);
    wt(1);
    chk(pos_error_o, 1);
    bus(1, 8'h00, 0);
    wt(1);
    chk(pos_error_o, 0);
    results();
  end
endmodule
bind plr_top plr_checker chk_u (.clk_i, .rst_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .enc_valid_i, .act_pos_o,
  .current_setpoint_i, .current_cmd_o, .irq_o);
